/* rtl/spicr_pkg.sv */
package spicr_pkg;
   localparam logic [11:0] OFS_ID = 12'h000;
   localparam logic [11:0] OFS_CMD = 12'h004;
   localparam int VEN_LSB = 0;
   localparam int DEV_LSB = 16;
   localparam int CMD_IO = 0;
   localparam int CMD_MEM = 1;
   localparam int CMD_BM = 2;
   localparam int CMD_PAR = 6;
   localparam int CMD_ERR = 8;
   localparam int CMD_INTX = 10;
   localparam int STS_SSE = 30;
   localparam logic [15:0] CMD_RST = 16'h0000;
   localparam logic [15:0] CMD_WMASK = 16'h0547;
   localparam logic STS_SSE_RST = 1'b0;
   localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

   typedef struct packed {
      logic valid;
      logic wr;
      logic [11:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } spicr_cfg_s;

   typedef struct packed {
      logic valid;
      logic [15:0] part_id;
      logic [15:0] maker_id;
   } spicr_idload_s;

   typedef struct packed {
      logic valid;
      logic is_io;
      logic is_mem;
      logic non_posted;
   } spicr_txn_s;

   typedef enum logic [1:0] {
      TX_NONE = 2'b00,
      TX_ACCEPT = 2'b01,
      TX_IGNORE = 2'b10,
      TX_UR = 2'b11
   } spicr_disp_e;
endpackage

/* rtl/spicr_gate.sv */
`timescale 1ns/10ps
module spicr_gate
   import spicr_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [15:0] i_cmd,
   input wire spicr_txn_s i_pri_txn,
   input wire spicr_txn_s i_dn_txn,
   input wire logic i_own_intx,
   input wire logic i_fwd_intx,
   input wire logic i_err_det,
   input wire logic i_par_err,
   output logic o_pri_accept,
   output logic o_pri_ignore,
   output logic o_up_fwd,
   output logic o_ur_cpl,
   output logic o_dn_drop,
   output logic o_intx_msg,
   output logic o_intx_fwd,
   output logic o_err_msg,
   output logic o_par_act,
   output logic o_sse_set
);
   logic pri_hit;
   logic dn_io_mem;

   assign pri_hit = (i_pri_txn.is_io && i_cmd[CMD_IO]) || (i_pri_txn.is_mem && i_cmd[CMD_MEM]);
   assign dn_io_mem = i_dn_txn.valid && (i_dn_txn.is_io || i_dn_txn.is_mem);

   // primary side decode
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_pri_accept <= 1'b0;
         o_pri_ignore <= 1'b0;
      end
      else
      begin
         o_pri_accept <= i_pri_txn.valid && pri_hit;
         o_pri_ignore <= i_pri_txn.valid && !pri_hit;
      end
   end

   // upstream forwarding under bus mastering
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_up_fwd <= 1'b0;
         o_ur_cpl <= 1'b0;
         o_dn_drop <= 1'b0;
      end
      else
      begin
         o_up_fwd <= dn_io_mem && i_cmd[CMD_BM];
         o_ur_cpl <= dn_io_mem && !i_cmd[CMD_BM] && i_dn_txn.non_posted;
         o_dn_drop <= dn_io_mem && !i_cmd[CMD_BM] && !i_dn_txn.non_posted;
      end
   end

   // messages and error policy
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_intx_msg <= 1'b0;
         o_intx_fwd <= 1'b0;
         o_err_msg <= 1'b0;
         o_par_act <= 1'b0;
         o_sse_set <= 1'b0;
      end
      else
      begin
         o_intx_msg <= i_own_intx && !i_cmd[CMD_INTX];
         o_intx_fwd <= i_fwd_intx;
         o_err_msg <= i_err_det && i_cmd[CMD_ERR];
         o_sse_set <= i_err_det && i_cmd[CMD_ERR];
         o_par_act <= i_par_err && i_cmd[CMD_PAR];
      end
   end

   sequence s_dn_request_no_bm;
      i_dn_txn.valid && (i_dn_txn.is_io || i_dn_txn.is_mem) && !i_cmd[CMD_BM];
   endsequence
   sequence s_ur_returned;
      o_ur_cpl && !o_up_fwd;
   endsequence

   chk_no_bm_ur: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_dn_request_no_bm and i_dn_txn.non_posted |=> s_ur_returned)
      else $error("non-posted request without bus mastering got no UR completion");
   chk_no_bm_fwd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_up_fwd |-> $past(i_cmd[CMD_BM]))
      else $error("request forwarded upstream while bus mastering off");
   chk_bm_forward: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      dn_io_mem && i_cmd[CMD_BM] |=> o_up_fwd && !o_ur_cpl && !o_dn_drop)
      else $error("request not forwarded upstream with bus mastering on");
   chk_pri_space: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_pri_txn.valid && i_pri_txn.is_io && !i_pri_txn.is_mem |=>
      (o_pri_accept == $past(i_cmd[CMD_IO])) && (o_pri_ignore != o_pri_accept))
      else $error("io space enable not honoured");
   chk_intx_block: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_own_intx && i_fwd_intx && i_cmd[CMD_INTX] |=> !o_intx_msg && o_intx_fwd)
      else $error("interrupt disable handling wrong");
   chk_err_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_err_msg |-> $past(i_err_det) && $past(i_cmd[CMD_ERR]))
      else $error("error reported while reporting disabled");
   chk_parity_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_par_err |=> o_par_act == $past(i_cmd[CMD_PAR]))
      else $error("parity response does not follow enable");
endmodule

/* rtl/spicr_regs.sv */
`timescale 1ns/10ps
// Function
// - maker identifier, read-only, bits 15:0 of dword 0, loadable by smbus/eeprom.
// - part identifier, read-only, bits 31:16 of dword 0, loadable likewise.
// - command bit 0 read-write, reset 0; gates response to primary io requests.
// - command bit 1 read-write, reset 0; gates response to primary memory requests.
// - bit 2 clear: no upstream io/memory requests, downstream ones are unsupported.
// - non-posted request without bus mastering gets an unsupported-request completion.
// - bit 2 set: forward io and memory reads and writes upstream.
// - command bits 3, 4, 5, 7, 9 read zero and ignore writes.
// - bit 6 read-write, reset 0; enables normal parity error handling.
// - bit 8 read-write, reset 0; gates fatal and non-fatal error reporting.
// - bit 10 blocks own interrupt messages, never forwarding from downstream.
// - signaled-system-error status bit 30 set on reported error, write one clears.
module spicr_regs
   import spicr_pkg::*;
#(
   // arbitrary neutral defaults, replaced by smbus or eeprom load
   parameter logic [15:0] MAKER_ID_DFLT = 16'hA5A5,
   parameter logic [15:0] PART_ID_DFLT = 16'h0001
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire spicr_cfg_s i_cfg,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_ack,
   input wire spicr_idload_s i_id_load,
   input wire spicr_txn_s i_pri_txn,
   input wire spicr_txn_s i_dn_txn,
   input wire logic i_own_intx,
   input wire logic i_fwd_intx,
   input wire logic i_err_det,
   input wire logic i_par_err,
   output logic o_pri_accept,
   output logic o_pri_ignore,
   output logic o_up_fwd,
   output logic o_ur_cpl,
   output logic o_dn_drop,
   output logic o_intx_msg,
   output logic o_intx_fwd,
   output logic o_err_msg,
   output logic o_par_act,
   output logic [15:0] o_cmd
);
   logic [15:0] maker_id_r;
   logic [15:0] part_id_r;
   logic [15:0] cmd_r;
   logic [15:0] cmd_nxt;
   logic sse_r;
   logic sse_set;
   logic wr_id;
   logic wr_cmd;
   logic [31:0] rd_nxt;

   assign wr_id = i_cfg.valid && i_cfg.wr && (i_cfg.addr == OFS_ID);
   assign wr_cmd = i_cfg.valid && i_cfg.wr && (i_cfg.addr == OFS_CMD);

   // identifiers ignore config writes, only the load port changes them
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         maker_id_r <= MAKER_ID_DFLT;
         part_id_r <= PART_ID_DFLT;
      end
      else if (i_id_load.valid)
      begin
         maker_id_r <= i_id_load.maker_id;
         part_id_r <= i_id_load.part_id;
      end
   end

   // byte-lane merge, only implemented bits take write data
   always_comb
   begin
      cmd_nxt = cmd_r;
      if (i_cfg.be[0])
      begin
         cmd_nxt[7:0] = i_cfg.wdata[7:0];
      end
      if (i_cfg.be[1])
      begin
         cmd_nxt[15:8] = i_cfg.wdata[15:8];
      end
      cmd_nxt = cmd_nxt & CMD_WMASK;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         cmd_r <= CMD_RST;
      end
      else if (wr_cmd)
      begin
         cmd_r <= cmd_nxt;
      end
   end

   // a set in the same cycle as a write-one-clear wins
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         sse_r <= STS_SSE_RST;
      end
      else if (sse_set)
      begin
         sse_r <= 1'b1;
      end
      else if (wr_cmd && i_cfg.be[3] && i_cfg.wdata[STS_SSE])
      begin
         sse_r <= 1'b0;
      end
   end

   always_comb
   begin
      rd_nxt = RD_UNMAPPED;
      case (i_cfg.addr)
         OFS_ID: rd_nxt = {part_id_r, maker_id_r};
         OFS_CMD:
         begin
            rd_nxt[15:0] = cmd_r & CMD_WMASK;
            rd_nxt[STS_SSE] = sse_r;
         end
         default: rd_nxt = RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_cfg_rdata <= RD_UNMAPPED;
         o_cfg_ack <= 1'b0;
      end
      else
      begin
         o_cfg_ack <= i_cfg.valid;
         if (i_cfg.valid && !i_cfg.wr)
         begin
            o_cfg_rdata <= rd_nxt;
         end
      end
   end

   assign o_cmd = cmd_r;

   spicr_gate u_gate (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_cmd(cmd_r),
      .i_pri_txn(i_pri_txn),
      .i_dn_txn(i_dn_txn),
      .i_own_intx(i_own_intx),
      .i_fwd_intx(i_fwd_intx),
      .i_err_det(i_err_det),
      .i_par_err(i_par_err),
      .o_pri_accept(o_pri_accept),
      .o_pri_ignore(o_pri_ignore),
      .o_up_fwd(o_up_fwd),
      .o_ur_cpl(o_ur_cpl),
      .o_dn_drop(o_dn_drop),
      .o_intx_msg(o_intx_msg),
      .o_intx_fwd(o_intx_fwd),
      .o_err_msg(o_err_msg),
      .o_par_act(o_par_act),
      .o_sse_set(sse_set)
   );

   sequence s_cmd_write_legacy;
      wr_cmd && i_cfg.be[0] && i_cfg.be[1] && (i_cfg.wdata[15:0] == 16'hFAB8);
   endsequence

   chk_id_readonly: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_id && !i_id_load.valid |=> $stable(maker_id_r) && $stable(part_id_r))
      else $error("identifier changed by config write");
   chk_id_load: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_id_load.valid ##1 (i_cfg.valid && !i_cfg.wr && i_cfg.addr == OFS_ID)
      |=> o_cfg_rdata == {$past(i_id_load.part_id, 2), $past(i_id_load.maker_id, 2)})
      else $error("loaded identifier not read back");
   chk_legacy_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s_cmd_write_legacy |=> cmd_r == 16'h0000)
      else $error("legacy or reserved command bits took write data");
   chk_cmd_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_cmd && i_cfg.be[0] |=> cmd_r[CMD_IO] == $past(i_cfg.wdata[CMD_IO])
      && cmd_r[CMD_PAR] == $past(i_cfg.wdata[CMD_PAR]))
      else $error("command bits 0 or 6 not written");
   chk_sse_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_err_det && cmd_r[CMD_ERR] |=> ##1 sse_r)
      else $error("signaled system error not set");
   chk_sse_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(sse_r) |-> $past(i_err_det, 2))
      else $error("signaled system error set without cause");
   chk_reset_cmd: assert property (@(posedge i_clk)
      $past(i_sys_rst) |-> cmd_r == CMD_RST && !sse_r)
      else $error("command not cleared by reset");
endmodule

/* tb/spicr_host.sv */
`timescale 1ns/10ps
module spicr_host
   import spicr_pkg::*;
(
   input wire logic i_clk,
   input wire logic [31:0] i_rdata,
   input wire logic i_ack,
   output spicr_cfg_s o_cfg
);
   initial
   begin
      o_cfg = '{1'b0, 1'b0, 12'hFFF, 4'h0, 32'h0};
   end
   // one request per call; a released bus shows inverted lines, never the last value
   task automatic cfg(input logic wr, input logic [11:0] addr, input logic [3:0] be,
      input logic [31:0] wd, output logic [31:0] rd, output logic ack);
      @(negedge i_clk);
      o_cfg = '{1'b1, wr, addr, be, wd};
      @(negedge i_clk);
      ack = i_ack;
      rd = i_rdata;
      o_cfg = '{1'b0, ~wr, ~addr, ~be, ~wd};
   endtask
endmodule

/* tb/spicr_regs_tb.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module spicr_regs_tb
   import spicr_pkg::*;
;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   spicr_cfg_s cfg;
   spicr_idload_s idl = '0;
   spicr_txn_s pri = '0;
   spicr_txn_s dn = '0;
   logic own = 1'b0, fwd = 1'b0, err = 1'b0, par = 1'b0;
   logic [31:0] rdata;
   logic ack;
   logic [8:0] outs;
   logic [15:0] cmd;
   int mismatches = 0;
   int tests_run = 0;
   int ks [8] = '{0, 0, 1, 1, 2, 3, 4, 5};
   logic [2:0] ts [8] = '{3'h4, 3'h2, 3'h5, 3'h2, 3'h0, 3'h0, 3'h0, 3'h0};
   logic [8:0] e_off [8] = '{9'h080, 9'h080, 9'h020, 9'h010, 9'h008, 9'h004, 9'h000, 9'h000};
   logic [8:0] e_on [8] = '{9'h100, 9'h100, 9'h040, 9'h040, 9'h000, 9'h004, 9'h002, 9'h001};

   always #50 i_clk = ~i_clk;

   spicr_regs spicr_regs_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg(cfg),
      .o_cfg_rdata(rdata), .o_cfg_ack(ack), .i_id_load(idl), .i_pri_txn(pri),
      .i_dn_txn(dn), .i_own_intx(own), .i_fwd_intx(fwd), .i_err_det(err),
      .i_par_err(par), .o_pri_accept(outs[8]), .o_pri_ignore(outs[7]),
      .o_up_fwd(outs[6]), .o_ur_cpl(outs[5]), .o_dn_drop(outs[4]),
      .o_intx_msg(outs[3]), .o_intx_fwd(outs[2]), .o_err_msg(outs[1]),
      .o_par_act(outs[0]), .o_cmd(cmd));

   spicr_host spicr_host_i (.i_clk(i_clk), .i_rdata(rdata), .i_ack(ack), .o_cfg(cfg));

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] rd;
      logic k;
      spicr_host_i.cfg(1'b0, a, 4'hF, 32'h0, rd, k);
      `CHK(k, 1'b1)
      `CHK(rd, e)
   endtask

   task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
      logic [31:0] rd;
      logic k;
      spicr_host_i.cfg(1'b1, a, be, d, rd, k);
      `CHK(k, 1'b1)
   endtask

   task automatic fire(input int k, input logic [2:0] t, input logic [8:0] e);
      @(negedge i_clk);
      case (k)
         0: pri = {1'b1, t};
         1: dn = {1'b1, t};
         2: own = 1'b1;
         3: fwd = 1'b1;
         4: err = 1'b1;
         6: {own, fwd} = 2'b11;
         default: par = 1'b1;
      endcase
      @(negedge i_clk);
      pri = '0;
      dn = '0;
      {own, fwd, err, par} = 4'h0;
      `CHK(outs, e)
   endtask

   task automatic t_reset_ids();
      `CHK(cmd, 16'h0000)
      rd_chk(OFS_ID, {16'h0001, 16'hA5A5});
      rd_chk(OFS_CMD, 32'h00000000);
      wr(OFS_ID, 4'hF, 32'h12345678);
      rd_chk(OFS_ID, {16'h0001, 16'hA5A5});
      @(negedge i_clk);
      idl = '{1'b1, 16'h5A3C, 16'hC3E1};
      // read is presented in the cycle right after the load
      fork
         rd_chk(OFS_ID, 32'h5A3CC3E1);
         begin
            @(negedge i_clk);
            idl = '0;
         end
      join
      rd_chk(12'h100, 32'h00000000);
   endtask

   task automatic t_gating();
      for (int i = 0; i < 8; i++)
         fire(ks[i], ts[i], e_off[i]);
      rd_chk(OFS_CMD, 32'h00000000);
      wr(OFS_CMD, 4'h3, 32'h0000FFFF);
      `CHK(cmd, 16'h0547)
      rd_chk(OFS_CMD, 32'h00000547);
      for (int i = 0; i < 8; i++)
         fire(ks[i], ts[i], e_on[i]);
      fire(6, 3'h0, 9'h004);
      rd_chk(OFS_CMD, 32'h40000547);
      wr(OFS_CMD, 4'h8, 32'h40000000);
      rd_chk(OFS_CMD, 32'h00000547);
      wr(OFS_CMD, 4'h3, 32'h00000147);
      fire(2, 3'h0, 9'h008);
      fire(6, 3'h0, 9'h00C);
      wr(OFS_CMD, 4'h3, 32'h00000000);
      fire(4, 3'h0, 9'h000);
      rd_chk(OFS_CMD, 32'h00000000);
      wr(OFS_CMD, 4'h3, 32'h0000FAB8);
      `CHK(cmd, 16'h0000)
   endtask

   task automatic stop_test();
      $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      repeat (20) @(negedge i_clk);
      i_sys_rst = 1'b0;
      t_reset_ids();
      t_gating();
      stop_test();
   end

   initial
   begin
      #(2000 * 100);
      mismatches++;
      stop_test();
   end
endmodule
